// ===== common/idle_gate_pkg.sv
package idle_gate_pkg;
  // Register word indices, and byte addresses at four times the index
  localparam logic [3:0]  SETUP_IDX      = 4'h1;
  localparam logic [3:0]  STATE_IDX      = 4'h2;
  localparam logic [3:0]  FAULT_IDX      = 4'h3;
  localparam logic [7:0]  SETUP_ADDR     = 8'h04;
  localparam logic [7:0]  STATE_ADDR     = 8'h08;
  localparam logic [7:0]  FAULT_ADDR     = 8'h0C;
  // Field positions
  localparam int          ACCEL_BIT      = 9;
  localparam int          FETCH_BIT      = 8;
  localparam int          MEM_BIT        = 7;
  localparam int          IO_BIT         = 6;
  localparam int          DATA_BIT       = 5;
  localparam int          CFG_LSB        = 1;
  localparam int          CORE_BIT       = 0;
  localparam int          FAULT_BIT      = 0;
  // Values
  localparam logic [3:0]  CFG_VALID      = 4'h7;
  localparam logic [15:0] SETUP_MASK     = 16'h03FF;
  localparam logic [15:0] STATE_MASK     = 16'h03E1;
  localparam logic [15:0] WAKE_MASK      = 16'h0161;
  localparam logic [15:0] PORT_REQ_MASK  = 16'h01E0;
  localparam logic [15:0] CORE_DEP_MASK  = 16'h0160;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam int          WAKE_CYCLES    = 3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ===== common/gate_if.sv
`timescale 1ns/1ps
`default_nettype none
// Gate state carried from the control logic to the recogniser
interface gate_if;
  logic core_gated;    // Core clock currently stopped
  logic wake;          // Unmasked interrupt wakes domain
  logic int_recognised; // Pulse three cycles after wake
  modport ctrl (output core_gated, output wake, input int_recognised);
  modport rec (input core_gated, input wake, output int_recognised);
endinterface
`default_nettype wire

// ===== verilog/wake_recognise.sv
`timescale 1ns/1ps
`default_nettype none
// Delays wake of core into interrupt recognition pulse
module wake_recognise (
  input  wire logic aclk,
  input  wire logic aresetn,
  gate_if.rec       gif
);
  logic [idle_gate_pkg::WAKE_CYCLES-1:0] pipe; // Wake delay line

  // Shift a wake of a gated core through the delay line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[idle_gate_pkg::WAKE_CYCLES-2:0], gif.wake & gif.core_gated};
    end
  end

  assign gif.int_recognised = pipe[idle_gate_pkg::WAKE_CYCLES-1];

  // Recognition follows wake by exactly three cycles
  a_wake_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    gif.wake && gif.core_gated |-> ##3 gif.int_recognised)
    else $error("interrupt not recognised three cycles after wake");
endmodule
`default_nettype wire

// ===== verilog/cpu_domain_idle_gating.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - State bit 9 shows accelerator gated.
// - State bit 8 shows fetch port gated.
// - State bit 7 shows memory port gated.
// - State bit 6 shows I/O port gated.
// - State bit 5 shows data port gated.
// - State bit 0 shows core gated.
// - Port requests need config field 0111.
// - Fetch/data/I/O gating needs core gating.
// - Invalid request: bus fault, nothing changes.
// - Valid request copies setup into state.
// - Gated core halts right after sleep.
// - Interrupt clears bits 0, 5, 6, 8.
// - Interrupt recognised three cycles after wake.
// - Interrupts leave memory and accelerator gated.
// - Setup register read/write, resets zero.
// - Setup writes alone change no gates.
module cpu_domain_idle_gating (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side
  input  wire logic        sleep_exec,
  input  wire logic        unmasked_irq,
  output logic             bus_fault_flag,
  output logic             core_halt,
  output logic             int_recognised,
  output logic             core_gated_flag,
  output logic             data_port_gated_flag,
  output logic             io_port_gated_flag,
  output logic             mem_port_gated_flag,
  output logic             fetch_port_gated_flag,
  output logic             accel_gated_flag
);
  logic [15:0] sleep_setup_reg;  // Pending configuration
  logic [15:0] sleep_state_reg;  // Applied gate state
  logic        fault_sticky;     // Bus fault status bit
  logic        req_invalid;      // Sleep request rejected
  logic        sleep_valid;      // Accepted sleep request
  logic [3:0]  sleep_cfg_field;  // Config field of setup
  logic        aw_held;          // Write address captured
  logic        w_held;           // Write data captured
  logic [7:0]  aw_addr;          // Captured write address
  logic [31:0] w_data;           // Captured write data
  logic [3:0]  w_strb;           // Captured byte enables
  logic        do_write;         // Both halves present
  logic        setup_wr;         // Write hits setup register
  logic        fault_clr;        // Write one clears fault
  logic        addr_ok_w;        // Write address mapped
  logic [31:0] next_rdata;       // Read mux value
  logic        addr_ok_r;        // Read address mapped
  gate_if      gif ();           // Link to recogniser

  // Validity check of the pending configuration
  always_comb begin
    sleep_cfg_field = sleep_setup_reg[idle_gate_pkg::CFG_LSB +: 4];
    req_invalid = 1'b0;
    if (|(sleep_setup_reg & idle_gate_pkg::PORT_REQ_MASK) &&
        sleep_cfg_field != idle_gate_pkg::CFG_VALID) begin
      req_invalid = 1'b1;
    end
    if (|(sleep_setup_reg & idle_gate_pkg::CORE_DEP_MASK) &&
        !sleep_setup_reg[idle_gate_pkg::CORE_BIT]) begin
      req_invalid = 1'b1;
    end
  end

  // Only a valid request touches the gates
  assign sleep_valid = sleep_exec & ~req_invalid;

  // Write channel capture; address and data in either order
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write decode
  assign addr_ok_w = (aw_addr == idle_gate_pkg::SETUP_ADDR) ||
                     (aw_addr == idle_gate_pkg::STATE_ADDR) ||
                     (aw_addr == idle_gate_pkg::FAULT_ADDR);
  assign setup_wr  = do_write && aw_addr == idle_gate_pkg::SETUP_ADDR;
  assign fault_clr = do_write && aw_addr == idle_gate_pkg::FAULT_ADDR &&
                     w_strb[0] && w_data[idle_gate_pkg::FAULT_BIT];

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= idle_gate_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok_w ? idle_gate_pkg::RESP_OKAY : idle_gate_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Setup register, byte lanes honoured, reserved bits kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_setup_reg <= idle_gate_pkg::REG_RESET;
    end else if (setup_wr) begin
      if (w_strb[0]) begin
        sleep_setup_reg[7:0] <= w_data[7:0] & idle_gate_pkg::SETUP_MASK[7:0];
      end
      if (w_strb[1]) begin
        sleep_setup_reg[15:8] <= w_data[15:8] & idle_gate_pkg::SETUP_MASK[15:8];
      end
    end
  end

  // Applied gate state; wake beats a same-cycle sleep on its bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_state_reg <= idle_gate_pkg::REG_RESET;
    end else begin
      if (sleep_valid) begin
        sleep_state_reg <= sleep_setup_reg & idle_gate_pkg::STATE_MASK;
      end
      if (unmasked_irq) begin
        // Memory port and accelerator bits left alone
        sleep_state_reg <= (sleep_valid ? sleep_setup_reg & idle_gate_pkg::STATE_MASK : sleep_state_reg)
                           & ~idle_gate_pkg::WAKE_MASK;
      end
    end
  end

  // Sticky bus fault; a new fault wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_sticky <= 1'b0;
    end else if (sleep_exec && req_invalid) begin
      fault_sticky <= 1'b1;
    end else if (fault_clr) begin
      fault_sticky <= 1'b0;
    end
  end

  // Gate flags, asynchronous wake folded combinationally into core, data, I/O and fetch flags
  assign core_gated_flag       = sleep_state_reg[idle_gate_pkg::CORE_BIT] & ~unmasked_irq;
  assign data_port_gated_flag  = sleep_state_reg[idle_gate_pkg::DATA_BIT] & ~unmasked_irq;
  assign io_port_gated_flag    = sleep_state_reg[idle_gate_pkg::IO_BIT] & ~unmasked_irq;
  assign fetch_port_gated_flag = sleep_state_reg[idle_gate_pkg::FETCH_BIT] & ~unmasked_irq;
  assign mem_port_gated_flag   = sleep_state_reg[idle_gate_pkg::MEM_BIT];
  assign accel_gated_flag      = sleep_state_reg[idle_gate_pkg::ACCEL_BIT];
  assign bus_fault_flag        = fault_sticky;
  // Halt straight after an accepted sleep that stops the core
  assign core_halt = core_gated_flag |
                     (sleep_valid & sleep_setup_reg[idle_gate_pkg::CORE_BIT] & ~unmasked_irq);

  // Recogniser link
  assign gif.core_gated = sleep_state_reg[idle_gate_pkg::CORE_BIT];
  assign gif.wake       = unmasked_irq;
  assign int_recognised = gif.int_recognised;

  wake_recognise u_rec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .gif     (gif)
  );

  // Read decode
  // Address taken whenever no read answer is pending
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    next_rdata = '0;
    addr_ok_r  = 1'b1;
    // Unmapped reads answer zero with an error
    unique case (s_axi_araddr)
      idle_gate_pkg::SETUP_ADDR: next_rdata = {16'h0000, sleep_setup_reg};
      idle_gate_pkg::STATE_ADDR: next_rdata = {16'h0000, sleep_state_reg};
      idle_gate_pkg::FAULT_ADDR: next_rdata = {31'h0, fault_sticky};
      default:                   addr_ok_r  = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= idle_gate_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= addr_ok_r ? idle_gate_pkg::RESP_OKAY : idle_gate_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  // Invalid sleep raises the sticky fault
  a_invalid_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_exec && req_invalid |=> bus_fault_flag)
    else $error("invalid sleep did not raise fault");
  // Invalid sleep leaves the gates alone
  a_invalid_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_exec && req_invalid && !unmasked_irq |=> $stable(sleep_state_reg))
    else $error("invalid sleep changed gate state");

  // Port requests without the fixed config field refused
  a_cfg_check: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_exec && (|(sleep_setup_reg & idle_gate_pkg::PORT_REQ_MASK))
    && sleep_setup_reg[4:1] != idle_gate_pkg::CFG_VALID |-> !sleep_valid)
    else $error("bad config accepted");
  // Fetch, data or I/O port without core refused
  a_core_dep: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_exec && !sleep_setup_reg[0] && (sleep_setup_reg[8] || sleep_setup_reg[6] || sleep_setup_reg[5])
    |-> !sleep_valid)
    else $error("port gating without core accepted");
  // Request breaking neither condition accepted
  a_valid_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_exec && (sleep_setup_reg[4:1] == idle_gate_pkg::CFG_VALID || sleep_setup_reg[8:5] == 4'h0)
    && (sleep_setup_reg[0] || !(sleep_setup_reg[8] || sleep_setup_reg[6] || sleep_setup_reg[5]))
    |-> sleep_valid)
    else $error("valid sleep refused");

  // Accepted sleep copies the setup word
  a_valid_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_valid && !unmasked_irq |=> sleep_state_reg == ($past(sleep_setup_reg) & idle_gate_pkg::STATE_MASK))
    else $error("valid sleep not copied");
  // Setup writes alone move no gate
  a_setup_nogate: assert property (@(posedge aclk) disable iff (!aresetn)
    !sleep_exec && !unmasked_irq |=> $stable(sleep_state_reg))
    else $error("gate state moved without sleep");

  // Interrupt clears core and three port bits
  a_wake_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    unmasked_irq |=> sleep_state_reg[0] == 1'b0 && sleep_state_reg[5] == 1'b0
    && sleep_state_reg[6] == 1'b0 && sleep_state_reg[8] == 1'b0)
    else $error("interrupt did not wake core ports");
  // Interrupt ungates the woken flags at once
  a_wake_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    unmasked_irq |-> !core_gated_flag && !data_port_gated_flag
    && !io_port_gated_flag && !fetch_port_gated_flag)
    else $error("interrupt left a core port flag gated");
  // Interrupt keeps memory port and accelerator
  a_wake_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    unmasked_irq && !sleep_exec |=> $stable(sleep_state_reg[9]) && $stable(sleep_state_reg[7]))
    else $error("interrupt touched memory or accelerator");

  // Reserved state bits stay zero
  a_state_resv: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_state_reg & ~idle_gate_pkg::STATE_MASK) == 16'h0000)
    else $error("state reserved bit set");
  // Core halts with the sleep and is still halted one cycle later unless woken
  a_halt_core: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_valid && sleep_setup_reg[0] && !unmasked_irq |-> core_halt ##1 (core_halt || unmasked_irq))
    else $error("core not halted after sleep");

  // Cover points for the main scenarios
  c_valid_sleep: cover property (@(posedge aclk) sleep_valid && sleep_setup_reg[0]);
  c_invalid_sleep: cover property (@(posedge aclk) sleep_exec && req_invalid);
  c_wake: cover property (@(posedge aclk) unmasked_irq && sleep_state_reg[0]);
  c_port_only: cover property (@(posedge aclk) sleep_valid && !sleep_setup_reg[0] && sleep_setup_reg[7]);
  c_fault_clear: cover property (@(posedge aclk) fault_clr && bus_fault_flag);
endmodule
`default_nettype wire

// ===== testbench/core_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core and interrupt source facing the gating block
module core_irq_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic core_halt,
  input  wire logic int_recognised,
  output logic      sleep_exec,
  output logic      unmasked_irq
);
  // Quiet at time zero; no DMA traffic is ever modelled, so memory gating is safe
  initial begin
    sleep_exec = 1'b0;
    unmasked_irq = 1'b0;
  end
  // Interrupt logic withdraws its request once the core has taken it
  always @(posedge aclk) begin
    if (!aresetn || int_recognised) begin
      unmasked_irq <= 1'b0;
    end
  end
  // One sleep instruction alone in its cycle; halt is sampled meanwhile
  task automatic issue_sleep(output logic halt);
    sleep_exec <= 1'b1;
    @(negedge aclk);
    halt = core_halt;
    @(posedge aclk);
    sleep_exec <= 1'b0;
  endtask
  // Raise or withdraw the unmasked interrupt
  task automatic set_irq(input logic v);
    unmasked_irq <= v;
  endtask
endmodule
`default_nettype wire

// ===== testbench/cpu_domain_idle_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the CPU-domain idle gating block
module cpu_domain_idle_gating_tb;
  logic             aclk = 1'b0;     // System clock
  logic             aresetn = 1'b0;  // Reset, low active
  logic [7:0]       awaddr = 8'h00;  // Write address
  logic [7:0]       araddr = 8'h00;  // Read address
  logic [31:0]      wdata = 32'h0;   // Write data
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid, sleep_exec, unmasked_irq;
  logic [1:0]       bresp, rresp;    // Responses
  logic [31:0]      rdata;           // Read data
  logic             fault, halt, int_rec, core, data, io, mem, fetch, accel;
  wire logic [6:0]  flags;           // Fault, then accelerator down to core
  int               err_count = 0;   // Mismatches
  int               n_checks = 0;    // Comparisons
  assign flags = {fault, accel, fetch, mem, io, data, core};
  // Clock, 50 ns period
  always #25 aclk = ~aclk;
  cpu_domain_idle_gating dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_exec(sleep_exec), .unmasked_irq(unmasked_irq),
    .bus_fault_flag(fault), .core_halt(halt), .int_recognised(int_rec), .core_gated_flag(core),
    .data_port_gated_flag(data), .io_port_gated_flag(io), .mem_port_gated_flag(mem),
    .fetch_port_gated_flag(fetch), .accel_gated_flag(accel));
  core_irq_model cpu (.aclk(aclk), .aresetn(aresetn), .core_halt(halt), .int_recognised(int_rec),
    .sleep_exec(sleep_exec), .unmasked_irq(unmasked_irq));
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask
  // A wait ran out
  task automatic tmo(input string nm);
    $display("unexpected %s: expected answer seen none", nm);
    err_count++;
    print_verdict();
  endtask
  // Write one word; readies sampled mid-cycle, so stable at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; !b_t; n++) begin
      if (n == 40) tmo("write");
      @(negedge aclk);
      if (!aw_t) aw_t = awready;
      if (!w_t) w_t = wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    // Spare edge so the next transfer never reassigns a strobe in this step
    @(posedge aclk);
  endtask
  // Read one word and judge data and response
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    logic a_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    a_t = 1'b0;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; !r_t; n++) begin
      if (n == 40) tmo("read");
      @(negedge aclk);
      if (!a_t) a_t = arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    // Spare edge so the next transfer never reassigns a strobe in this step
    @(posedge aclk);
    chk(nm, d, e);
    chk({nm, " resp"}, {30'h0, r}, {30'h0, er});
  endtask
  // Judge fault and gate flags mid-cycle
  task automatic fl(input logic [6:0] e);
    @(negedge aclk);
    chk("flags", {25'h0, flags}, {25'h0, e});
    @(posedge aclk);
  endtask
  // Load setup, execute sleep, judge the halt
  task automatic slp(input logic [15:0] v, input logic eh);
    logic [1:0] r;
    logic h;
    wr(idle_gate_pkg::SETUP_ADDR, {16'h0, v}, r);
    cpu.issue_sleep(h);
    chk("core halt", {31'h0, h}, {31'h0, eh});
  endtask
  // Reset values, setup alone, read-only state, unmapped place
  task automatic t_regs();
    logic [1:0] r;
    rdchk(idle_gate_pkg::SETUP_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "setup reset");
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "state reset");
    wr(idle_gate_pkg::SETUP_ADDR, 32'hFFFFFFFF, r);
    rdchk(idle_gate_pkg::SETUP_ADDR, 32'h3FF, idle_gate_pkg::RESP_OKAY, "setup back");
    fl(7'h00);
    wr(idle_gate_pkg::STATE_ADDR, 32'hFFFF, r);
    chk("state write resp", {30'h0, r}, {30'h0, idle_gate_pkg::RESP_OKAY});
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "state write");
    wr(8'h10, 32'h1, r);
    chk("unmapped write", {30'h0, r}, {30'h0, idle_gate_pkg::RESP_SLVERR});
    rdchk(8'h10, 32'h0, idle_gate_pkg::RESP_SLVERR, "unmapped read");
  endtask
  // Invalid requests fault and change nothing
  task automatic t_invalid();
    logic [15:0] bad [6] = '{16'h0021, 16'h0081, 16'h002D, 16'h004E, 16'h010E, 16'h002E};
    logic [1:0] r;
    foreach (bad[i]) begin
      slp(bad[i], 1'b0);
      fl(7'h40);
      rdchk(idle_gate_pkg::STATE_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "state kept");
      rdchk(idle_gate_pkg::FAULT_ADDR, 32'h1, idle_gate_pkg::RESP_OKAY, "fault reg");
      wr(idle_gate_pkg::FAULT_ADDR, 32'h1, r);
      fl(7'h00);
    end
  endtask
  // Accelerator alone needs no config field and keeps the core running
  task automatic t_accel();
    slp(16'h0200, 1'b0);
    fl(7'h20);
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h200, idle_gate_pkg::RESP_OKAY, "accel state");
    slp(16'h0000, 1'b0);
    fl(7'h00);
  endtask
  // Reset in mid-run clears every gate and the setup register
  task automatic t_reset();
    slp(16'h028E, 1'b0);
    fl(7'h28);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fl(7'h00);
    rdchk(idle_gate_pkg::SETUP_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "setup after reset");
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h0, idle_gate_pkg::RESP_OKAY, "state after reset");
  endtask
  // Everything gated, then an interrupt wakes part of the domain
  task automatic t_wake();
    int n;
    slp(16'h03EF, 1'b1);
    fl(7'h3F);
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h3E1, idle_gate_pkg::RESP_OKAY, "full state");
    cpu.set_irq(1'b1);
    @(negedge aclk);
    chk("woken flags", {25'h0, flags}, 32'h28);
    for (n = 0; n < 10 && int_rec !== 1'b1; n++) @(negedge aclk);
    chk("recognise delay", n, 3);
    @(posedge aclk);
    rdchk(idle_gate_pkg::STATE_ADDR, 32'h280, idle_gate_pkg::RESP_OKAY, "woken state");
    slp(16'h000E, 1'b0);
    fl(7'h00);
  endtask
  // Reset, then every scenario
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_invalid();
    t_accel();
    t_wake();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
